/* inc/pulse_train_params.svh */
// constants for the pulse train and frequency output channel
`ifndef PULSE_TRAIN_PARAMS_SVH
`define PULSE_TRAIN_PARAMS_SVH

// reference clock rate in hertz (200 MHz)
`define PTO_CLK_HZ 32'h0BEBC200
// frequency caps in hertz: 100 kHz, 10 kHz, 100 Hz
`define PTO_FMAX_HS_HZ 32'h000186A0
`define PTO_FMAX_HSOFF_HZ 32'h00002710
`define PTO_FMAX_STD_HZ 32'h00000064
// four quarter ticks per output period
`define PTO_QUARTER_SHIFT 2

// register byte offsets
`define PTO_OFS_CTRL 4'h0
`define PTO_OFS_SETPOINT 4'h4
`define PTO_OFS_STATUS 4'h8
`define PTO_OFS_POSITION 4'hC

// control word width, status bit positions
`define PTO_CTRL_W 7
`define PTO_STS_RUN 0
`define PTO_STS_REQ 1
`define PTO_STS_PH_LO 2
`define PTO_STS_PH_HI 3
`define PTO_STS_CLAMP 4

// reset values
`define PTO_CTRL_RST 7'h00
`define PTO_SETPOINT_RST 32'h00000000
`define PTO_POSITION_RST 32'h00000000

`endif

/* inc/pulse_train_pkg.sv */
// types shared by the pulse train channel
package pulse_train_pkg;

	// pulse train signal encodings
	typedef enum logic [1:0] {
		SIG_PULSE_DIR = 2'h0,
		SIG_UP_DOWN = 2'h1,
		SIG_QUAD_1X = 2'h2,
		SIG_QUAD_4X = 2'h3
	} sig_type_t;

	// channel run state
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_RUN = 2'b10
	} run_state_t;

	// control word, bit 6 first
	typedef struct packed {
		logic dir_neg;
		logic std_out;
		logic high_speed;
		sig_type_t sig_type;
		logic pulse_train_mode;
		logic software_run_request;
	} ctrl_t;

	// register bus request
	typedef struct packed {
		logic [3:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;

endpackage : pulse_train_pkg

/* rtl/phase_divider.sv */
// quarter-period tick generator with period-aligned step reload
`timescale 1ns/1ps
`default_nettype none
`include "pulse_train_params.svh"
module phase_divider #(
	parameter int STEP_W = 20,
	parameter int ACC_W = 28,
	parameter logic [ACC_W-1:0] MODULUS = ACC_W'(`PTO_CLK_HZ)
) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic clear,
	input wire logic load,
	input wire logic [STEP_W-1:0] step_in,
	output logic [STEP_W-1:0] active_step,
	output logic tick
);

	logic [STEP_W-1:0] nxt_step;
	logic [ACC_W:0] sum;
	logic [ACC_W-1:0] acc_ff;

	// step only swapped on load, so a running period keeps its rate
	always_comb begin
		nxt_step = load ? step_in : active_step;
		sum = {1'b0, acc_ff} + (ACC_W+1)'(nxt_step);
	end

	// accumulator: tick rate is step times ref_clk over modulus
	always_ff @(posedge ref_clk) begin
		if (!nrst || clear) begin
			acc_ff <= '0;
			active_step <= '0;
			tick <= 1'b0;
		end else begin
			active_step <= nxt_step;
			if (sum >= {1'b0, MODULUS}) begin
				acc_ff <= ACC_W'(sum - {1'b0, MODULUS});
				tick <= 1'b1;
			end else begin
				acc_ff <= ACC_W'(sum);
				tick <= 1'b0;
			end
		end
	end

endmodule : phase_divider
`default_nettype wire

/* rtl/pulse_train_frequency_output.sv */
// pulse train and frequency output channel with register port
`timescale 1ns/1ps
`default_nettype none
`include "pulse_train_params.svh"
module pulse_train_frequency_output
	import pulse_train_pkg::*;
#(
	parameter int STEP_W = 20,
	parameter int ACC_W = 28
) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire reg_req_t reg_req,
	output logic [31:0] reg_rdata,
	output logic pulse_output_a,
	output logic pulse_output_b,
	output logic run_active_flag
);

	ctrl_t ctrl_ff;
	ctrl_t nxt_ctrl;
	ctrl_t cfg_ff;
	ctrl_t nxt_cfg;
	logic [31:0] setpoint_ff;
	logic [31:0] position_ff;
	logic [31:0] nxt_position;
	run_state_t state_ff;
	run_state_t nxt_state;
	logic [1:0] cnt_ff;
	logic [1:0] nxt_cnt;
	logic [1:0] nxt_wave;
	logic wr_ctrl;
	logic wr_setpoint;
	logic wr_position;
	logic running;
	logic start;
	logic stop;
	logic go;
	logic tick;
	logic period_end;
	logic load_div;
	logic clear_div;
	logic count_ev;
	logic [STEP_W-1:0] step_in;
	logic [STEP_W-1:0] active_step;
	logic [31:0] status;

	// cap for the selected output type
	function automatic logic [31:0] limit_hz(input ctrl_t c);
		if (c.std_out)
			return `PTO_FMAX_STD_HZ;
		else if (c.high_speed)
			return `PTO_FMAX_HS_HZ;
		else
			return `PTO_FMAX_HSOFF_HZ;
	endfunction : limit_hz

	// hertz setpoint to quarter-tick step, clamped to the cap
	function automatic logic [STEP_W-1:0] step_of(input ctrl_t c, input logic [31:0] sp);
		logic [31:0] lim;
		logic [31:0] hz;
		lim = limit_hz(c);
		hz = (sp > lim) ? lim : sp;
		return STEP_W'(hz << `PTO_QUARTER_SHIFT);
	endfunction : step_of

	// output levels {a, b} for a quarter index and a configuration
	function automatic logic [1:0] wave(input logic [1:0] q, input ctrl_t c);
		logic qa;
		logic qb;
		qa = q[0] ^ q[1];
		qb = q[1];
		if (!c.pulse_train_mode)
			return {qa, 1'b0};
		case (c.sig_type)
			SIG_PULSE_DIR: return {qa, c.dir_neg};
			SIG_UP_DOWN: return c.dir_neg ? {1'b0, qa} : {qa, 1'b0};
			SIG_QUAD_1X, SIG_QUAD_4X: return c.dir_neg ? {qb, qa} : {qa, qb};
			default: return 2'h0;
		endcase
	endfunction : wave

	// address decode; unmapped writes are dropped
	always_comb begin
		wr_ctrl = reg_req.wr && (reg_req.addr == `PTO_OFS_CTRL);
		wr_setpoint = reg_req.wr && (reg_req.addr == `PTO_OFS_SETPOINT);
		wr_position = reg_req.wr && (reg_req.addr == `PTO_OFS_POSITION);
		nxt_ctrl = ctrl_t'(reg_req.wdata[`PTO_CTRL_W-1:0]);
	end

	// sequence starts only on a 0 to 1 edge of the run request
	always_comb begin
		running = (state_ff == ST_RUN);
		start = !running && wr_ctrl && nxt_ctrl.software_run_request && !ctrl_ff.software_run_request;
		stop = running && wr_ctrl && !nxt_ctrl.software_run_request;
		go = start || (running && !stop);
		period_end = running && tick && (cnt_ff == 2'h3);
		load_div = start || period_end;
		clear_div = !go;
	end

	// configuration latched per period so a period never changes shape
	always_comb begin
		if (start)
			nxt_cfg = nxt_ctrl;
		else if (period_end)
			nxt_cfg = ctrl_ff;
		else
			nxt_cfg = cfg_ff;
		step_in = step_of(nxt_cfg, setpoint_ff);
	end

	// quarter index and next output levels
	always_comb begin
		if (start)
			nxt_cnt = 2'h0;
		else if (running && tick)
			nxt_cnt = cnt_ff + 2'h1;
		else
			nxt_cnt = cnt_ff;
		nxt_wave = wave(nxt_cnt, nxt_cfg);
	end

	// increment events: every quarter in 4x, otherwise the quarter where A (B in negative up/down) rises
	always_comb begin
		count_ev = 1'b0;
		if (running && !stop && tick && cfg_ff.pulse_train_mode) begin
			if (cfg_ff.sig_type == SIG_QUAD_4X)
				count_ev = 1'b1;
			else if (cfg_ff.sig_type == SIG_QUAD_1X)
				// B leads when negative, so A only rises entering quarter two
				count_ev = (nxt_cnt == (cfg_ff.dir_neg ? 2'h2 : 2'h1));
			else
				count_ev = (nxt_cnt == 2'h1);
		end
	end

	// position: a clearing write and a same-cycle increment both take effect
	always_comb begin
		nxt_position = wr_position ? `PTO_POSITION_RST : position_ff;
		if (count_ev)
			nxt_position = cfg_ff.dir_neg ? nxt_position - 32'h00000001 : nxt_position + 32'h00000001;
	end

	// run state machine
	always_comb begin
		case (state_ff)
			ST_IDLE: nxt_state = start ? ST_RUN : ST_IDLE;
			ST_RUN: nxt_state = stop ? ST_IDLE : ST_RUN;
			default: nxt_state = ST_IDLE;
		endcase
	end

	phase_divider #(
		.STEP_W(STEP_W),
		.ACC_W(ACC_W)
	) u_phase_divider (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.clear(clear_div),
		.load(load_div),
		.step_in(step_in),
		.active_step(active_step),
		.tick(tick)
	);

	// software registers
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			ctrl_ff <= ctrl_t'(`PTO_CTRL_RST);
			setpoint_ff <= `PTO_SETPOINT_RST;
		end else begin
			if (wr_ctrl)
				ctrl_ff <= nxt_ctrl;
			if (wr_setpoint)
				setpoint_ff <= reg_req.wdata;
		end
	end

	// state and flag; flag drops in the same edge as the request
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			state_ff <= ST_IDLE;
			run_active_flag <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			run_active_flag <= (nxt_state == ST_RUN);
		end
	end

	// sequence state; idle forces low outputs and quarter zero
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			cnt_ff <= 2'h0;
			cfg_ff <= ctrl_t'(`PTO_CTRL_RST);
			pulse_output_a <= 1'b0;
			pulse_output_b <= 1'b0;
		end else if (go) begin
			cnt_ff <= nxt_cnt;
			cfg_ff <= nxt_cfg;
			pulse_output_a <= nxt_wave[1];
			pulse_output_b <= nxt_wave[0];
		end else begin
			cnt_ff <= 2'h0;
			pulse_output_a <= 1'b0;
			pulse_output_b <= 1'b0;
		end
	end

	// generated increments, signed two's complement
	always_ff @(posedge ref_clk) begin
		if (!nrst)
			position_ff <= `PTO_POSITION_RST;
		else
			position_ff <= nxt_position;
	end

	// status word
	always_comb begin
		status = 32'h00000000;
		status[`PTO_STS_RUN] = run_active_flag;
		status[`PTO_STS_REQ] = ctrl_ff.software_run_request;
		status[`PTO_STS_PH_HI:`PTO_STS_PH_LO] = cnt_ff;
		status[`PTO_STS_CLAMP] = (setpoint_ff > limit_hz(ctrl_ff));
	end

	// read data valid only in the cycle after the strobe, zero elsewhere
	always_ff @(posedge ref_clk) begin
		if (!nrst || !reg_req.rd) begin
			reg_rdata <= 32'h00000000;
		end else begin
			case (reg_req.addr)
				`PTO_OFS_CTRL: reg_rdata <= 32'(ctrl_ff);
				`PTO_OFS_SETPOINT: reg_rdata <= setpoint_ff;
				`PTO_OFS_STATUS: reg_rdata <= status;
				`PTO_OFS_POSITION: reg_rdata <= position_ff;
				default: reg_rdata <= 32'h00000000;
			endcase
		end
	end

	// checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);

	AST_FREQ_CAP: assert property (
		running |-> (32'(active_step) <= (limit_hz(cfg_ff) << `PTO_QUARTER_SHIFT)))
		else $error("active step above output cap");

	AST_HS_REACH: assert property (
		(start && nxt_ctrl.high_speed && !nxt_ctrl.std_out && setpoint_ff >= `PTO_FMAX_HS_HZ)
		|=> (32'(active_step) == (`PTO_FMAX_HS_HZ << `PTO_QUARTER_SHIFT)))
		else $error("high speed cap not reached");

	AST_HALF_DUTY: assert property (
		running && !stop && tick && !cfg_ff.pulse_train_mode && !cnt_ff[0]
		|=> $changed(pulse_output_a) && !pulse_output_b)
		else $error("frequency output edge missing");

	AST_PD_DIR: assert property (
		running && $past(running) && cfg_ff.pulse_train_mode && cfg_ff.sig_type == SIG_PULSE_DIR
		|-> pulse_output_b == cfg_ff.dir_neg)
		else $error("direction level wrong");

	AST_UD_EXCL: assert property (
		cfg_ff.pulse_train_mode && cfg_ff.sig_type == SIG_UP_DOWN |-> !(pulse_output_a && pulse_output_b))
		else $error("up and down pulses overlap");

	AST_QUAD_GRAY: assert property (
		running && $past(running) && cfg_ff.pulse_train_mode && cfg_ff.sig_type[1]
		|-> !($changed(pulse_output_a) && $changed(pulse_output_b)))
		else $error("quadrature phases moved together");

	AST_QUAD_LEAD: assert property (
		running && cfg_ff.pulse_train_mode && cfg_ff.sig_type[1] && $rose(cfg_ff.dir_neg ? pulse_output_a
		: pulse_output_b) |-> (cfg_ff.dir_neg ? pulse_output_b : pulse_output_a))
		else $error("quadrature lead wrong");

	AST_INC_1X: assert property (
		running && cfg_ff.pulse_train_mode && cfg_ff.sig_type == SIG_QUAD_1X && !$past(wr_position)
		&& $rose(pulse_output_a)
		|-> position_ff == $past(position_ff) + (cfg_ff.dir_neg ? 32'hFFFFFFFF : 32'h00000001))
		else $error("1x increment not counted");

	AST_INC_4X: assert property (
		count_ev && cfg_ff.sig_type == SIG_QUAD_4X && !wr_position
		|=> position_ff == $past(position_ff) + ($past(cfg_ff.dir_neg) ? 32'hFFFFFFFF : 32'h00000001))
		else $error("4x increment not counted");

	AST_STOP_NOW: assert property (
		$fell(ctrl_ff.software_run_request) |-> !run_active_flag && !pulse_output_a && !pulse_output_b)
		else $error("stop not immediate");

	AST_STEP_HOLD: assert property (
		$changed(active_step) |-> $past(load_div) || $past(clear_div) || !$past(nrst))
		else $error("step changed inside a period");

	AST_RESET_LOW: assert property (disable iff (1'b0)
		!nrst |=> !pulse_output_a && !pulse_output_b && position_ff == 32'h00000000 && cnt_ff == 2'h0)
		else $error("reset did not clear outputs");

	COV_FREQ_RUN: cover property (running && !cfg_ff.pulse_train_mode && period_end);
	COV_QUAD4_NEG: cover property (count_ev && cfg_ff.sig_type == SIG_QUAD_4X && cfg_ff.dir_neg);
	COV_STOP_HIGH: cover property (stop && pulse_output_a);
	COV_CLEAR_COUNT: cover property (count_ev && wr_position);

endmodule : pulse_train_frequency_output
`default_nettype wire

/* test/step_drive_model.sv */
// drive or encoder input model that counts increments seen on A and B
`timescale 1ns/1ps
`default_nettype none
module step_drive_model
	import pulse_train_pkg::*;
(
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic clr,
	input wire sig_type_t sig_type,
	input wire logic a,
	input wire logic b,
	output logic signed [31:0] pos_ff
);
	logic a_ff;
	logic b_ff;

	// decode edges as the matching drive input would; falling edges matter only at 4x
	always_ff @(posedge ref_clk) begin
		a_ff <= a;
		b_ff <= b;
		if (!nrst || clr) begin
			pos_ff <= '0;
		end else begin
			case (sig_type)
				SIG_PULSE_DIR: if (a && !a_ff) pos_ff <= b ? pos_ff - 32'h1 : pos_ff + 32'h1;
				SIG_UP_DOWN: pos_ff <= pos_ff + 32'(a & ~a_ff) - 32'(b & ~b_ff);
				SIG_QUAD_1X: if (a && !a_ff) pos_ff <= b ? pos_ff - 32'h1 : pos_ff + 32'h1;
				default: if ({a, b} != {a_ff, b_ff}) pos_ff <= (a_ff ^ b) ? pos_ff - 32'h1 : pos_ff + 32'h1;
			endcase
		end
	end
endmodule : step_drive_model
`default_nettype wire

/* test/tb_pulse_train_frequency_output.sv */
// self-checking bench for the pulse train channel
`timescale 1ns/1ps
`default_nettype none
`include "pulse_train_params.svh"
module tb_pulse_train_frequency_output
	import pulse_train_pkg::*;
;
	logic ref_clk = 1'b0;
	logic nrst = 1'b0;
	reg_req_t reg_req = '0;
	logic [31:0] reg_rdata;
	logic pulse_output_a;
	logic pulse_output_b;
	logic run_active_flag;
	logic drive_clr = 1'b0;
	sig_type_t drv_type = SIG_PULSE_DIR;
	logic signed [31:0] drv_pos;
	int errors = 0;
	int cmp_count = 0;
	logic [31:0] rd_q;
	logic [31:0] caps [4];
	logic [31:0] sp;
	ctrl_t c;

	pulse_train_frequency_output dut_u (.ref_clk(ref_clk), .nrst(nrst), .reg_req(reg_req), .reg_rdata(reg_rdata),
		.pulse_output_a(pulse_output_a), .pulse_output_b(pulse_output_b), .run_active_flag(run_active_flag));
	step_drive_model drv_u (.ref_clk(ref_clk), .nrst(nrst), .clr(drive_clr), .sig_type(drv_type),
		.a(pulse_output_a), .b(pulse_output_b), .pos_ff(drv_pos));

	// 200 MHz clock
	initial forever #2.5 ref_clk = ~ref_clk;

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic conclude;
		$display("comparisons %0d, mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : conclude

	task automatic waitc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : waitc

	// one idle edge after each strobe so a following call never rewrites it in the same step
	task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
		reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge ref_clk);
		reg_req <= '0;
		@(posedge ref_clk);
	endtask : wr_reg

	task automatic rd_reg(input logic [3:0] a);
		reg_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge ref_clk);
		reg_req <= '0;
		#1 rd_q = reg_rdata;
		@(posedge ref_clk);
	endtask : rd_reg

	// expected {A,B} in quarter k of a run
	function automatic logic [1:0] exp_ab(input ctrl_t cw, input int k);
		logic qa;
		logic qb;
		qa = (k % 4 == 1) || (k % 4 == 2);
		qb = (k % 4 == 2) || (k % 4 == 3);
		if (!cw.pulse_train_mode) return {qa, 1'b0};
		case (cw.sig_type)
			SIG_PULSE_DIR: return {qa, cw.dir_neg};
			SIG_UP_DOWN: return cw.dir_neg ? {1'b0, qa} : {qa, 1'b0};
			default: return cw.dir_neg ? {qb, qa} : {qa, qb};
		endcase
	endfunction : exp_ab

	// ten quarters at 100 kHz, sampled mid-quarter so tick jitter cannot matter
	task automatic run_mode(input ctrl_t cw);
		logic signed [31:0] n;
		n = !cw.pulse_train_mode ? 0 : (cw.sig_type == SIG_QUAD_4X ? 9 : 3);
		// negative 1x counts on A rising, a quarter later, so one rise fewer in the window
		if (cw.pulse_train_mode && cw.sig_type == SIG_QUAD_1X && cw.dir_neg) n = 2;
		if (cw.dir_neg) n = -n;
		drv_type <= cw.sig_type;
		// earlier frequency runs leave edges in the model, so start it from zero
		drive_clr <= 1'b1;
		@(posedge ref_clk);
		drive_clr <= 1'b0;
		wr_reg(`PTO_OFS_SETPOINT, `PTO_FMAX_HS_HZ);
		wr_reg(`PTO_OFS_CTRL, 32'(cw));
		#1 check(32'(run_active_flag), 32'h1);
		for (int k = 0; k <= 9; k++) begin
			waitc(k == 0 ? 248 : 500);
			#1 check(32'({pulse_output_a, pulse_output_b}), 32'(exp_ab(cw, k)));
		end
		rd_reg(`PTO_OFS_POSITION);
		check(rd_q, n);
		if (cw.pulse_train_mode) check(drv_pos, n);
		// running, request echoed, quarter one, setpoint not clamped
		rd_reg(`PTO_OFS_STATUS);
		check(rd_q, 32'h00000007);
		rd_reg(`PTO_OFS_CTRL);
		check(rd_q, 32'(cw));
		wr_reg(`PTO_OFS_CTRL, 32'h0);
		#1 check(32'({run_active_flag, pulse_output_a, pulse_output_b}), 32'h0);
		wr_reg(`PTO_OFS_POSITION, $urandom);
	endtask : run_mode

	// hang guard
	initial begin
		repeat (100000) @(posedge ref_clk);
		errors++;
		conclude;
	end

	initial begin
		void'($urandom(32'h3A25C41E));
		caps = '{`PTO_FMAX_HSOFF_HZ, `PTO_FMAX_HS_HZ, `PTO_FMAX_STD_HZ, `PTO_FMAX_STD_HZ};
		waitc(3);
		nrst <= 1'b1;
		waitc(1);
		for (int i = 0; i < 4; i++) begin
			rd_reg(4'(i * 4));
			check(rd_q, 32'h0);
		end
		check(32'({run_active_flag, pulse_output_a, pulse_output_b}), 32'h0);
		rd_reg(4'($urandom) | 4'h1);
		check(rd_q, 32'h0);
		sp = 32'h1 + $urandom % `PTO_FMAX_HSOFF_HZ;
		wr_reg(`PTO_OFS_SETPOINT, sp);
		rd_reg(`PTO_OFS_SETPOINT);
		check(rd_q, sp);
		// cap per output kind; standard output wins over high speed
		for (int i = 0; i < 4; i++) begin
			wr_reg(`PTO_OFS_CTRL, 32'(i << 4));
			for (int j = 0; j < 2; j++) begin
				wr_reg(`PTO_OFS_SETPOINT, caps[i] + 32'(j));
				rd_reg(`PTO_OFS_STATUS);
				check(32'(rd_q[`PTO_STS_CLAMP]), 32'(j));
			end
		end
		// 100 kHz request without high speed runs at the 10 kHz cap
		wr_reg(`PTO_OFS_SETPOINT, `PTO_FMAX_HS_HZ);
		wr_reg(`PTO_OFS_CTRL, 32'h1);
		waitc(2748);
		#1 check(32'(pulse_output_a), 32'h0);
		waitc(4750);
		#1 check(32'(pulse_output_a), 32'h1);
		wr_reg(`PTO_OFS_CTRL, 32'h0);
		// setpoint halved mid-period applies only from the next period
		wr_reg(`PTO_OFS_CTRL, 32'h11);
		waitc(748);
		#1 check(32'(pulse_output_a), 32'h1);
		wr_reg(`PTO_OFS_SETPOINT, 32'h0000C350);
		waitc(998);
		#1 check(32'(pulse_output_a), 32'h0);
		waitc(1000);
		#1 check(32'(pulse_output_a), 32'h0);
		waitc(750);
		#1 check(32'(pulse_output_a), 32'h1);
		wr_reg(`PTO_OFS_CTRL, 32'h0);
		// every encoding in both directions, then the plain frequency output
		for (int t = 0; t < 4; t++) begin
			for (int d = 0; d < 2; d++) begin
				c = '{dir_neg: d[0], std_out: 1'b0, high_speed: 1'b1, sig_type: sig_type_t'(t),
					pulse_train_mode: 1'b1, software_run_request: 1'b1};
				run_mode(c);
			end
		end
		c.pulse_train_mode = 1'b0;
		run_mode(c);
		// reset in mid-run
		wr_reg(`PTO_OFS_SETPOINT, `PTO_FMAX_HS_HZ);
		wr_reg(`PTO_OFS_CTRL, 32'h1F);
		waitc(748);
		nrst <= 1'b0;
		waitc(1);
		// release on the clock edge, one reset edge is enough
		nrst <= 1'b1;
		#1 check(32'({run_active_flag, pulse_output_a, pulse_output_b}), 32'h0);
		rd_reg(`PTO_OFS_POSITION);
		check(rd_q, 32'h0);
		conclude;
	end
endmodule : tb_pulse_train_frequency_output
`default_nettype wire
